// ==== verif/rcm_host.sv ====
/* Serial-port host model: one 16-bit mode-0 frame per call, 800 ns serial clock.
   Assumes the bench routes its pins to the dual pins in register mode. */
module rcm_host (
    input wire logic clk,     // bench clock
    input wire logic miso,    // serial out level
    input wire logic miso_oe, // serial out enable
    output logic     sck,     // serial clock
    output logic     mosi,    // serial data
    output logic     ss_n     // select, active low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sck = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
    end
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd, output logic oe_seen);
        rd = 8'h00;
        oe_seen = 1'b1;
        ss_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = f[i];
            repeat (4) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            // miso read late in the high phase: pin path needs about 6 clocks
            if (i < 8) begin
                rd = {rd[6:0], miso};
                oe_seen = oe_seen & miso_oe;
            end
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        ss_n = 1'b1;
        mosi = ~mosi; // released line: no stale level
        repeat (6) @(negedge clk);
    endtask : xfer
endmodule : rcm_host

// ==== verif/rcm_props.sv ====
/* Port checker for rcm_top: output sources, pin-mode defaults, serial out enable, gpio, lock flag.
   Assumes the top module's port names; bound at the foot of this file. */
module rcm_chk (
    input wire logic       clk,                    // clock
    input wire logic       rst_n,                  // sync reset
    input wire logic       port_select,            // mode level
    input wire logic       pin_bypass_mosi,        // dual pin
    input wire logic       pin_mute_n_sck,         // dual pin
    input wire logic       pin_clksel_ss_n,        // dual pin
    input wire logic       pin_miso_oe,            // serial out enable
    input wire logic       rate_lo_oe,             // gpio a enable
    input wire logic [1:0] rate_select,            // rate to pll
    input wire logic       core_lock,              // lock
    input wire logic [1:0] serial_out_a_src,       // source a
    input wire logic [1:0] serial_out_b_src,       // source b
    input wire logic       monitor_path_eq_select, // monitor source
    input wire logic       fast_lock,              // lock tuning
    input wire logic [1:0] out_vos,                // common-mode
    input wire logic [1:0] out_a_vod,              // swing a
    input wire logic       lock_late               // deadline missed
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking dcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_PIN_MUTE:
        assert property ((!port_select && !pin_mute_n_sck) [*8] |-> serial_out_a_src == 2'h0 && serial_out_b_src == 2'h0)
        else $error("outputs not muted");
    AST_PIN_BYPASS:
        assert property ((!port_select && pin_mute_n_sck && pin_bypass_mosi && !pin_clksel_ss_n) [*8]
            |-> serial_out_a_src == 2'h2 && serial_out_b_src == 2'h2) else $error("bypass pin ignored");
    AST_PIN_CLKOUT:
        assert property ((!port_select && pin_mute_n_sck && !pin_bypass_mosi && pin_clksel_ss_n && core_lock) [*8]
            |-> serial_out_a_src == 2'h1 && serial_out_b_src == 2'h3) else $error("clock out pin ignored");
    AST_OUT_A_LEGAL:
        assert property (serial_out_a_src != 2'h3) else $error("first output carries clock");
    AST_PIN_ONLY:
        assert property (!port_select [*8] |-> monitor_path_eq_select && out_vos == 2'h3 && out_a_vod == 2'h3
            && !fast_lock) else $error("register setting active in pin mode");
    AST_MISO_QUIET:
        assert property ((!port_select || pin_clksel_ss_n) [*8] |-> !pin_miso_oe) else $error("serial out driven");
    AST_GPIO_RATE:
        assert property (rate_lo_oe [*3] |-> !rate_select[0]) else $error("gpio pin still selects rate");
    AST_LATE_CLEAR:
        assert property (core_lock [*8] |-> !lock_late) else $error("late flag with lock held");
endmodule : rcm_chk

bind rcm_top rcm_chk u_chk (.*);

// ==== verif/tb_top.sv ====
/* Self-checking bench for rcm_top: pin table, register port, lock deadlines, gpio pins.
   Assumes rcm_host as serial host and shortened lock limits of 200, 120 and 50 cycles. */
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", n, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rcm_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, port_select = 1'b0, byp = 1'b0, mute_n = 1'b1, csel = 1'b0;
    logic       core_lock = 1'b0, core_sigdet = 1'b0, lo_drv = 1'b0, hi_drv = 1'b0, core_rate_frac = 1'b0;
    logic       ext_ref = 1'b0, input_switched = 1'b0, host_sck, host_mosi, host_ss_n, pin_miso_out, pin_miso_oe;
    logic       rate_lo_out, rate_lo_oe, rate_hi_out, rate_hi_oe, monitor_path_eq_select, long_trace_eq_boost;
    logic       fast_lock, out_invert, out_a_pd, out_b_pd, lock_late;
    logic [2:0] core_rate = 3'h0, signal_detect_threshold;
    logic [1:0] rate_select, serial_out_a_src, serial_out_b_src, out_vos, out_a_vod, out_b_vod;
    logic [1:0] out_a_deemph, out_b_deemph;
    logic [7:0] tbl [5] = '{8'h00, 8'hCA, 8'hA8, 8'hB7, 8'h95};
    int         err_total = 0, cmp_count = 0;
    wire logic  pin_bypass_mosi = port_select ? host_mosi : byp;
    wire logic  pin_mute_n_sck  = port_select ? host_sck : mute_n;
    wire logic  pin_clksel_ss_n = port_select ? host_ss_n : csel;
    wire logic  rate_lo_in      = rate_lo_oe ? rate_lo_out : lo_drv;
    wire logic  rate_hi_in      = rate_hi_oe ? rate_hi_out : hi_drv;
    always #50 clk = ~clk;
    rcm_top #(.ASYNC_LIMIT(200), .FAST_LIMIT(120), .SYNC_LIMIT(50)) DUT (.*);
    rcm_host HOST (.clk(clk), .miso(pin_miso_out), .miso_oe(pin_miso_oe), .sck(host_sck), .mosi(host_mosi),
                   .ss_n(host_ss_n));
    task automatic settle;
        repeat (8) @(negedge clk);
    endtask : settle
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       o;
        HOST.xfer({1'b0, a, d}, r, o);
    endtask : wr
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        logic       o;
        HOST.xfer({1'b1, a, 8'h00}, r, o);
        `CHK("read data", e, r)
        `CHK("miso enable", 1'b1, o)
    endtask : rdchk
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        settle();
        `CHK("pin defaults", 6'h3E, {monitor_path_eq_select, out_vos, out_a_vod, fast_lock})
        foreach (tbl[i]) begin
            {mute_n, byp, csel, core_lock} = tbl[i][7:4];
            settle();
            `CHK("pin sources", tbl[i][3:0], {serial_out_a_src, serial_out_b_src})
        end
        $display("test pin_mode done");
        {mute_n, byp, csel, core_lock} = 4'h9;
        port_select = 1'b1;
        core_sigdet = 1'b1;
        hi_drv = 1'b1;
        settle();
        `CHK("rate pins", 2'h2, rate_select)
        rdchk(ADDR_MON_PATH, RST_MON_PATH);
        rdchk(ADDR_OUT_EQ, RST_OUT_EQ);
        rdchk(7'h05, 8'h00);
        rdchk(ADDR_STATUS_PRI, 8'h11);
        rdchk(ADDR_STATUS_SEC, 8'h14);
        wr(ADDR_OUT_EQ, 8'h1B);
        wr(ADDR_MON_PATH, 8'h00);
        wr(ADDR_SIGDET_CFG, 8'h28);
        wr(ADDR_OUT_CTRL, 8'h32);
        wr(ADDR_OUT_DEEMPH, 8'h90);
        wr(ADDR_STATUS_PRI, 8'hFF);
        settle();
        `CHK("driver", 6'h3C, {long_trace_eq_boost, out_invert, out_a_pd, out_b_pd, out_vos})
        `CHK("monitor thr", 4'h5, {monitor_path_eq_select, signal_detect_threshold})
        `CHK("swing deemph", 8'h39, {out_a_vod, out_b_vod, out_a_deemph, out_b_deemph})
        `CHK("reg sources", 4'h5, {serial_out_a_src, serial_out_b_src})
        rdchk(ADDR_STATUS_PRI, 8'h11);
        $display("test registers done");
        wr(ADDR_LOCK_TUNE, FAST_LOCK_CODE);
        {core_lock, core_sigdet} = 2'h0;
        settle();
        core_sigdet = 1'b1;
        repeat (100) @(negedge clk);
        `CHK("fast early", 2'h2, {fast_lock, lock_late})
        repeat (50) @(negedge clk);
        `CHK("fast late", 1'b1, lock_late)
        core_lock = 1'b1;
        settle();
        `CHK("late clear", 1'b0, lock_late)
        {core_lock, input_switched} = 2'h1;
        repeat (6) @(negedge clk);
        input_switched = 1'b0;
        repeat (30) @(negedge clk);
        `CHK("sync early", 1'b0, lock_late)
        repeat (40) @(negedge clk);
        `CHK("sync late", 1'b1, lock_late)
        core_lock = 1'b1;
        $display("test lock_time done");
        lo_drv = 1'b1;
        wr(ADDR_GPIO_CFG, 8'h25);
        settle();
        `CHK("gpio a", 4'hE, {rate_lo_oe, rate_lo_out, rate_select})
        port_select = 1'b0;
        settle();
        `CHK("gpio kept", 3'h5, {rate_lo_oe, out_invert, monitor_path_eq_select})
        port_select = 1'b1;
        settle();
        rdchk(ADDR_OUT_EQ, 8'h1B);
        {ext_ref, core_rate_frac} = 2'h3;
        settle();
        rdchk(ADDR_STATUS_PRI, 8'h31);
        wr(ADDR_GPIO_CFG, 8'h1F);
        settle();
        `CHK("sigdet gpio", 6'h3C, {rate_hi_oe, rate_hi_out, rate_lo_oe, rate_lo_out, rate_select})
        $display("test gpio_rate done");
        stop_test();
    end
endmodule : tb_top

// ==== verilog/rcm_pkg.sv ====
/*
 * Constants, register map and types for the reclocker mode and pin control block.
 * Assumes one 10 MHz clock; all pins reach the block unsynchronised.
 */
// What this block does
// (R1) port-select low gives pin control, high gives serial-register control
// (R2) in pin control only the dedicated pins steer the device
// (R3) four dual pins: bypass/mute/clock-out select/return, else MOSI/SCK/SS/MISO; the MISO pin is left undriven in pin control
// (R4) rate pins stay rate selectors by default; register writes may make them GPIO
// (R5) entering register mode alone does not turn rate pins into GPIO
// (R6) rate pins reassigned as GPIO stay GPIO after return to pin control
// (R7) host should set long-trace boost bit for traces over 40 inches
// (R8) monitor-path select bit picks pre- or post-equalizer data, post by default
// (R9) signal-detect status reads in two status registers
// (R10) signal-detect threshold is a three-bit register field
// (R11) signal-detect status can be routed to the GPIO pins
// (R12) first output carries only reclocked or bypassed data
// (R13) second output carries reclocked data, recovered clock or bypassed data
// (R14) lock within 25 ms after new input or rate change
// (R15) lock within 1 ms after same-rate input switch
// (R16) writing 0xA3 to the tuning register cuts lock time under 15 ms
// (R17) register mode with external reference tells neighbouring HD and 3G rates apart
// (R18) registers invert output polarity and power down each driver
// (R19) registers set driver amplitude, common-mode offset and de-emphasis
// (R20) mode level switches dual pin functions without losing register contents
package rcm_pkg;
    localparam logic [6:0] ADDR_STATUS_PRI  = 7'h01;
    localparam logic [6:0] ADDR_STATUS_SEC  = 7'h03;
    localparam logic [6:0] ADDR_LOCK_TUNE   = 7'h0E;
    localparam logic [6:0] ADDR_OUT_EQ      = 7'h11;
    localparam logic [6:0] ADDR_OUT_CTRL    = 7'h12;
    localparam logic [6:0] ADDR_OUT_DEEMPH  = 7'h13;
    localparam logic [6:0] ADDR_MON_PATH    = 7'h14;
    localparam logic [6:0] ADDR_GPIO_CFG    = 7'h1F;
    localparam logic [6:0] ADDR_SIGDET_CFG  = 7'h20;

    localparam logic [7:0] RST_LOCK_TUNE    = 8'h00;
    localparam logic [7:0] RST_OUT_EQ       = 8'hC0;
    localparam logic [7:0] RST_OUT_CTRL     = 8'hF2;
    localparam logic [7:0] RST_OUT_DEEMPH   = 8'h00;
    localparam logic [7:0] RST_MON_PATH     = 8'h02;
    localparam logic [7:0] RST_GPIO_CFG     = 8'h00;
    localparam logic [7:0] RST_SIGDET_CFG   = 8'h00;
    localparam logic [7:0] FAST_LOCK_CODE   = 8'hA3;

    // field positions
    localparam int OEQ_INV     = 0;
    localparam int OEQ_BOOST   = 1;
    localparam int OEQ_PD_B    = 3;
    localparam int OEQ_PD_A    = 4;
    localparam int OEQ_VOS     = 6;
    localparam int OC_SCO      = 0;
    localparam int OC_MUTE_N   = 1;
    localparam int OC_BYPASS   = 2;
    localparam int OC_VOD_B    = 4;
    localparam int OC_VOD_A    = 6;
    localparam int DE_B        = 4;
    localparam int DE_A        = 6;
    localparam int MON_EQ_SEL  = 1;
    localparam int SD_THR      = 3;
    localparam int GC_EN_A     = 0;
    localparam int GC_EN_B     = 1;
    localparam int GC_OUT_A    = 2;
    localparam int GC_OUT_B    = 3;
    localparam int GC_SIGDET   = 4;
    localparam int GC_VAL_A    = 5;
    localparam int GC_VAL_B    = 6;
    localparam int SP_SIGDET   = 0;
    localparam int SP_RATE     = 1;
    localparam int SP_LOCK     = 4;
    localparam int SP_FRAC     = 5;
    localparam int SS_LATE     = 0;
    localparam int SS_GPIO_IN  = 1;
    localparam int SS_SIGDET   = 4;

    localparam logic [4:0] SPI_ADDR_BITS  = 5'd8;
    localparam logic [4:0] SPI_FRAME_BITS = 5'd16;

    // lock deadlines
    localparam int CLK_HZ        = 10_000_000;
    localparam int T_ASYNC_MS    = 25;
    localparam int T_FAST_MS     = 15;
    localparam int T_SYNC_MS     = 1;
    localparam int ASYNC_CYC     = T_ASYNC_MS * (CLK_HZ / 1000);
    localparam int FAST_CYC      = T_FAST_MS * (CLK_HZ / 1000);
    localparam int SYNC_CYC      = T_SYNC_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        RCM_SRC_MUTED   = 2'b00,
        RCM_SRC_RECLK   = 2'b01,
        RCM_SRC_BYPASS  = 2'b10,
        RCM_SRC_CLOCK   = 2'b11
    } rcm_src_t;

    typedef enum logic [1:0] {
        RCM_LK_IDLE = 2'b00,
        RCM_LK_WAIT = 2'b01,
        RCM_LK_DONE = 2'b10
    } rcm_lk_t;
endpackage : rcm_pkg

// ==== verilog/rcm_top.sv ====
/*
 * Mode select, dual-pin remap, serial register port, rate/GPIO pins,
 * output source selection and lock-time watch for the reclocker.
 * Assumes the analog core supplies lock, signal-detect and rate status;
 * all pin inputs are asynchronous and pass four flip-flops.
 */
module rcm_top
    import rcm_pkg::*;
#(
    parameter int ASYNC_LIMIT = ASYNC_CYC,
    parameter int FAST_LIMIT  = FAST_CYC,
    parameter int SYNC_LIMIT  = SYNC_CYC
) (
    input  wire logic       clk,              // 10 MHz
    input  wire logic       rst_n,            // sync reset
    input  wire logic       port_select,      // 0 pin mode, 1 register mode
    input  wire logic       pin_bypass_mosi,  // bypass / serial in
    input  wire logic       pin_mute_n_sck,   // mute_n / serial clock
    input  wire logic       pin_clksel_ss_n,  // clock_out_select / ss_n
    output logic            pin_miso_out,     // serial out level
    output logic            pin_miso_oe,      // serial out enable
    input  wire logic       rate_lo_in,       // rate_select_lo / general_io_a in
    output logic            rate_lo_out,      // general_io_a out
    output logic            rate_lo_oe,       // general_io_a enable
    input  wire logic       rate_hi_in,       // rate_select_hi / general_io_b in
    output logic            rate_hi_out,      // general_io_b out
    output logic            rate_hi_oe,       // general_io_b enable
    input  wire logic       core_lock,        // pll lock
    input  wire logic       core_sigdet,      // raw signal present
    input  wire logic [2:0] core_rate,        // locked rate class
    input  wire logic       core_rate_frac,   // 1/1.001 rate flag
    input  wire logic       ext_ref,          // external reference in use
    input  wire logic       input_switched,   // same-rate input change
    output logic [1:0]      rate_select,      // rate pins to pll
    output logic [1:0]      serial_out_a_src, // rcm_src_t
    output logic [1:0]      serial_out_b_src, // rcm_src_t
    output logic            monitor_path_eq_select, // 1 post-equalizer
    output logic            long_trace_eq_boost,    // extra eq boost
    output logic [2:0]      signal_detect_threshold,// detect level
    output logic            fast_lock,        // lock tuning active
    output logic            out_invert,       // driver polarity
    output logic            out_a_pd,         // driver a off
    output logic            out_b_pd,         // driver b off
    output logic [1:0]      out_vos,          // common-mode
    output logic [1:0]      out_a_vod,        // swing a
    output logic [1:0]      out_b_vod,        // swing b
    output logic [1:0]      out_a_deemph,     // de-emphasis a
    output logic [1:0]      out_b_deemph,     // de-emphasis b
    output logic            lock_late         // lock deadline missed
);
    // three-stage synchronisers, change accepted when stages 2 and 3 agree
    logic [8:0] s1_ff, s2_ff, s3_ff;
    logic [8:0] flt_ff;
    logic [8:0] raw;
    assign raw = {input_switched, core_sigdet, core_lock, rate_hi_in, rate_lo_in,
                  pin_clksel_ss_n, pin_mute_n_sck, pin_bypass_mosi, port_select};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_ff  <= 9'h000;
            s2_ff  <= 9'h000;
            s3_ff  <= 9'h000;
            flt_ff <= 9'h000;
        end else begin
            s1_ff <= raw;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            for (int i = 0; i < 9; i++) begin
                if (s2_ff[i] == s3_ff[i])
                    flt_ff[i] <= s3_ff[i];
            end
        end
    end

    logic spi_mode, p_bypass, p_mute_n, p_clksel, p_rlo, p_rhi, c_lock, c_sig, c_sw;
    assign spi_mode = flt_ff[0];                  // see (R1) (R20)
    assign p_bypass = flt_ff[1];
    assign p_mute_n = flt_ff[2];
    assign p_clksel = flt_ff[3];
    assign p_rlo    = flt_ff[4];
    assign p_rhi    = flt_ff[5];
    assign c_lock   = flt_ff[6];
    assign c_sig    = flt_ff[7];
    assign c_sw     = flt_ff[8];

    // serial port on the dual pins, only in register mode
    logic sck_q_ff;
    logic sck_rise, sck_fall, ss_act;
    assign ss_act   = spi_mode && !p_clksel;       // see (R3)
    assign sck_rise = ss_act && p_mute_n && !sck_q_ff;
    assign sck_fall = ss_act && !p_mute_n && sck_q_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_q_ff <= 1'b0;
        end else begin
            sck_q_ff <= p_mute_n;
        end
    end

    logic [4:0]  bits_ff;
    logic [15:0] shin_ff;
    logic [7:0]  shout_ff;
    logic        wr_stb;
    logic [15:0] nxt_shin;
    assign nxt_shin = {shin_ff[14:0], p_bypass};
    assign wr_stb   = sck_rise && (bits_ff == SPI_FRAME_BITS - 5'd1) && !shin_ff[14];

    logic [7:0] lock_tune_ff, out_eq_ff, out_ctrl_ff, deemph_ff, mon_ff, gpio_cfg_ff, sd_cfg_ff;
    logic [7:0] rd_data;

    function automatic logic [7:0] reg_read(input logic [6:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            ADDR_STATUS_PRI: begin
                d[SP_SIGDET]          = c_sig;      // see (R9)
                d[SP_RATE +: 3]       = core_rate;
                d[SP_LOCK]            = c_lock;
                d[SP_FRAC]            = core_rate_frac && ext_ref; // see (R17)
            end
            ADDR_STATUS_SEC: begin
                d[SS_LATE]            = lock_late;
                d[SS_GPIO_IN +: 2]    = {p_rhi, p_rlo};
                d[SS_SIGDET]          = c_sig;      // see (R9)
            end
            ADDR_LOCK_TUNE:  d = lock_tune_ff;
            ADDR_OUT_EQ:     d = out_eq_ff;
            ADDR_OUT_CTRL:   d = out_ctrl_ff;
            ADDR_OUT_DEEMPH: d = deemph_ff;
            ADDR_MON_PATH:   d = mon_ff;
            ADDR_GPIO_CFG:   d = gpio_cfg_ff;
            ADDR_SIGDET_CFG: d = sd_cfg_ff;
            default:         d = 8'h00;
        endcase
        return d;
    endfunction : reg_read

    always_comb rd_data = reg_read(shin_ff[6:0]);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bits_ff  <= 5'd0;
            shin_ff  <= 16'h0000;
            shout_ff <= 8'h00;
        end else if (!ss_act) begin
            bits_ff <= 5'd0;
        end else begin
            if (sck_rise && bits_ff != SPI_FRAME_BITS) begin
                shin_ff <= nxt_shin;
                bits_ff <= bits_ff + 5'd1;
            end
            if (sck_fall) begin
                if (bits_ff == SPI_ADDR_BITS)
                    shout_ff <= rd_data;
                else
                    shout_ff <= {shout_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_miso_out <= 1'b0;
            pin_miso_oe  <= 1'b0;
        end else begin
            pin_miso_oe  <= ss_act;                // see (R3)
            pin_miso_out <= ss_act && (bits_ff >= SPI_ADDR_BITS) && shout_ff[7];
        end
    end

    // register file keeps contents across mode changes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lock_tune_ff <= RST_LOCK_TUNE;
            out_eq_ff    <= RST_OUT_EQ;
            out_ctrl_ff  <= RST_OUT_CTRL;
            deemph_ff    <= RST_OUT_DEEMPH;
            mon_ff       <= RST_MON_PATH;
            gpio_cfg_ff  <= RST_GPIO_CFG;          // see (R4) (R5)
            sd_cfg_ff    <= RST_SIGDET_CFG;
        end else if (wr_stb) begin                 // see (R20)
            unique case (nxt_shin[14:8])              // whole frame only in nxt_shin
                ADDR_LOCK_TUNE:  lock_tune_ff <= nxt_shin[7:0];
                ADDR_OUT_EQ:     out_eq_ff    <= nxt_shin[7:0];
                ADDR_OUT_CTRL:   out_ctrl_ff  <= nxt_shin[7:0];
                ADDR_OUT_DEEMPH: deemph_ff    <= nxt_shin[7:0];
                ADDR_MON_PATH:   mon_ff       <= nxt_shin[7:0];
                ADDR_GPIO_CFG:   gpio_cfg_ff  <= nxt_shin[7:0];
                ADDR_SIGDET_CFG: sd_cfg_ff    <= nxt_shin[7:0];
                default:         ;
            endcase
        end
    end

    // rate pins / gpio: gpio config is never cleared by pin mode
    logic gpa, gpb;
    assign gpa = gpio_cfg_ff[GC_EN_A];             // see (R6)
    assign gpb = gpio_cfg_ff[GC_EN_B];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rate_select <= 2'b00;
            rate_lo_out <= 1'b0;
            rate_lo_oe  <= 1'b0;
            rate_hi_out <= 1'b0;
            rate_hi_oe  <= 1'b0;
        end else begin
            rate_select <= {gpb ? 1'b0 : p_rhi, gpa ? 1'b0 : p_rlo}; // see (R4)
            rate_lo_oe  <= gpa && gpio_cfg_ff[GC_OUT_A];
            rate_hi_oe  <= gpb && gpio_cfg_ff[GC_OUT_B];
            rate_lo_out <= gpio_cfg_ff[GC_SIGDET] ? c_sig : gpio_cfg_ff[GC_VAL_A]; // see (R11)
            rate_hi_out <= gpio_cfg_ff[GC_SIGDET] ? c_sig : gpio_cfg_ff[GC_VAL_B]; // see (R11)
        end
    end

    // effective controls: pins in pin mode, registers in register mode
    logic e_bypass, e_mute_n, e_clksel;
    assign e_bypass = spi_mode ? out_ctrl_ff[OC_BYPASS] : p_bypass; // see (R2)
    assign e_mute_n = spi_mode ? out_ctrl_ff[OC_MUTE_N] : p_mute_n;
    assign e_clksel = spi_mode ? out_ctrl_ff[OC_SCO]    : p_clksel;

    function automatic rcm_src_t pick_src(input logic b_side, input logic mute_n,
                                          input logic byp, input logic csel, input logic lk);
        rcm_src_t s;
        if (!mute_n)
            s = RCM_SRC_MUTED;
        else if (byp || !lk)
            s = (b_side && csel) ? RCM_SRC_MUTED : RCM_SRC_BYPASS;
        else if (b_side && csel)
            s = RCM_SRC_CLOCK;
        else
            s = RCM_SRC_RECLK;
        return s;
    endfunction : pick_src

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serial_out_a_src <= RCM_SRC_MUTED;
            serial_out_b_src <= RCM_SRC_MUTED;
        end else begin
            serial_out_a_src <= pick_src(1'b0, e_mute_n, e_bypass, e_clksel, c_lock); // see (R12)
            serial_out_b_src <= pick_src(1'b1, e_mute_n, e_bypass, e_clksel, c_lock); // see (R13)
        end
    end

    // register-only options fall back to defaults in pin mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            monitor_path_eq_select  <= RST_MON_PATH[MON_EQ_SEL];
            long_trace_eq_boost     <= RST_OUT_EQ[OEQ_BOOST];
            signal_detect_threshold <= RST_SIGDET_CFG[SD_THR +: 3];
            fast_lock               <= 1'b0;
            out_invert              <= RST_OUT_EQ[OEQ_INV];
            out_a_pd                <= RST_OUT_EQ[OEQ_PD_A];
            out_b_pd                <= RST_OUT_EQ[OEQ_PD_B];
            out_vos                 <= RST_OUT_EQ[OEQ_VOS +: 2];
            out_a_vod               <= RST_OUT_CTRL[OC_VOD_A +: 2];
            out_b_vod               <= RST_OUT_CTRL[OC_VOD_B +: 2];
            out_a_deemph            <= RST_OUT_DEEMPH[DE_A +: 2];
            out_b_deemph            <= RST_OUT_DEEMPH[DE_B +: 2];
        end else begin
            monitor_path_eq_select  <= spi_mode ? mon_ff[MON_EQ_SEL] : RST_MON_PATH[MON_EQ_SEL]; // see (R8)
            long_trace_eq_boost     <= spi_mode && out_eq_ff[OEQ_BOOST];                          // see (R7)
            signal_detect_threshold <= spi_mode ? sd_cfg_ff[SD_THR +: 3] : RST_SIGDET_CFG[SD_THR +: 3]; // see (R10)
            fast_lock               <= spi_mode && (lock_tune_ff == FAST_LOCK_CODE);              // see (R16)
            out_invert              <= spi_mode && out_eq_ff[OEQ_INV];                            // see (R18)
            out_a_pd                <= spi_mode && out_eq_ff[OEQ_PD_A];                           // see (R18)
            out_b_pd                <= spi_mode && out_eq_ff[OEQ_PD_B];
            out_vos                 <= spi_mode ? out_eq_ff[OEQ_VOS +: 2] : RST_OUT_EQ[OEQ_VOS +: 2]; // see (R19)
            out_a_vod               <= spi_mode ? out_ctrl_ff[OC_VOD_A +: 2] : RST_OUT_CTRL[OC_VOD_A +: 2];
            out_b_vod               <= spi_mode ? out_ctrl_ff[OC_VOD_B +: 2] : RST_OUT_CTRL[OC_VOD_B +: 2];
            out_a_deemph            <= spi_mode ? deemph_ff[DE_A +: 2] : RST_OUT_DEEMPH[DE_A +: 2];
            out_b_deemph            <= spi_mode ? deemph_ff[DE_B +: 2] : RST_OUT_DEEMPH[DE_B +: 2];
        end
    end

    // lock deadline watch
    rcm_lk_t     lk_ff;
    logic [24:0] lk_cnt_ff;
    logic [24:0] lk_lim_ff;
    logic        sig_q_ff;
    logic [2:0]  rate_q_ff;
    logic        new_in;
    assign new_in = (c_sig && !sig_q_ff) || (core_rate != rate_q_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lk_ff     <= RCM_LK_IDLE;
            lk_cnt_ff <= 25'd0;
            lk_lim_ff <= 25'd0;
            sig_q_ff  <= 1'b0;
            rate_q_ff <= 3'b000;
            lock_late <= 1'b0;
        end else begin
            sig_q_ff  <= c_sig;
            rate_q_ff <= core_rate;
            if (new_in) begin
                lk_ff     <= RCM_LK_WAIT;
                lk_cnt_ff <= 25'd0;
                lk_lim_ff <= fast_lock ? 25'(FAST_LIMIT) : 25'(ASYNC_LIMIT); // see (R14) (R16)
            end else if (c_sw) begin
                lk_ff     <= RCM_LK_WAIT;
                lk_cnt_ff <= 25'd0;
                lk_lim_ff <= 25'(SYNC_LIMIT);                                // see (R15)
            end else begin
                unique case (lk_ff)
                    RCM_LK_IDLE: ;
                    RCM_LK_WAIT: begin
                        if (c_lock) begin
                            lk_ff <= RCM_LK_DONE;
                        end else if (lk_cnt_ff >= lk_lim_ff) begin
                            lk_ff     <= RCM_LK_DONE;
                            lock_late <= 1'b1;
                        end else begin
                            lk_cnt_ff <= lk_cnt_ff + 25'd1;
                        end
                    end
                    RCM_LK_DONE: ;
                    default: lk_ff <= RCM_LK_IDLE;
                endcase
            end
            if (c_lock)
                lock_late <= 1'b0;
        end
    end
endmodule : rcm_top
